// ### hdl/csf_pkg.sv
// csf_pkg: constants, field positions and operation codes of the core status flag register.
// assumes one clock domain; the execute stage and the reset sequencer run on that clock.
package csf_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 5;
	localparam int          DATA_W          = 8;
	localparam logic [4:0]  STATUS_OFFSET   = 5'h03;
	localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          BIT_PIN_WAKE    = 7;
	localparam int          BIT_COMP_WAKE   = 6;
	localparam int          BIT_PAGE        = 5;
	localparam int          BIT_TIMEOUT     = 4;
	localparam int          BIT_POWERDOWN   = 3;
	localparam int          BIT_ZERO        = 2;
	localparam int          BIT_NIBBLE      = 1;
	localparam int          BIT_CARRY       = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  RST_UPPER       = 3'h0;
	localparam logic        RST_TIMEOUT     = 1'b1;
	localparam logic        RST_POWERDOWN   = 1'b1;
	localparam logic [2:0]  RST_ALU_FLAGS   = 3'h0;
	localparam logic [7:0]  RST_RESULT      = 8'h00;

	// ----------------------------------------------------------------
	// program memory paging
	// ----------------------------------------------------------------
	localparam int          PC_W            = 10;
	localparam int          PAGE_WORDS      = 512;
	localparam logic [9:0]  PAGE0_BASE      = 10'h000;
	localparam logic [9:0]  PAGE1_BASE      = 10'h200;

	// ----------------------------------------------------------------
	// operations issued by the execute stage
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE     = 4'h0,
		OP_ADD      = 4'h1,
		OP_SUB      = 4'h2,
		OP_AND      = 4'h3,
		OP_OR       = 4'h4,
		OP_XOR      = 4'h5,
		OP_ROT_R    = 4'h6,
		OP_ROT_L    = 4'h7,
		OP_CLR_FILE = 4'h8,
		OP_BIT_CLR  = 4'h9,
		OP_BIT_SET  = 4'hA,
		OP_MOV_FILE = 4'hB,
		OP_WATCHDOG_CLR = 4'hC,
		OP_HALT     = 4'hD
	} csf_op_type;

	// cause reported by the reset sequencer with a device reset pulse
	typedef enum logic [1:0] {
		CAUSE_POWER_UP  = 2'h0,
		CAUSE_PIN_WAKE  = 2'h1,
		CAUSE_COMP_WAKE = 2'h2,
		CAUSE_OTHER     = 2'h3
	} csf_cause_type;

endpackage

// ### hdl/csf_status_reg.sv
// csf_status_reg: 8-bit processor status register with its alu flag logic.
// assumes the execute stage, reset sequencer and watchdog share the clock and
// deliver one-cycle pulses; software reaches the register over a plain port.
// the watchdog, sleep and wake sources and the pc paging logic live outside.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

module csf_status_reg
	import csf_pkg::*;
#(
	parameter int PAGE_SIZE = csf_pkg::PAGE_WORDS
) (
	input  wire logic                         clock,
	input  wire logic                         rst_n,
	// register port
	input  wire logic [csf_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [csf_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                         reg_write,
	input  wire logic                         reg_read,
	output logic      [csf_pkg::DATA_W-1:0]   reg_rdata,
	// execute stage
	input  wire logic                         exec_valid,
	input  wire csf_pkg::csf_op_type          exec_op,
	input  wire logic [csf_pkg::DATA_W-1:0]   exec_file,
	input  wire logic [csf_pkg::DATA_W-1:0]   exec_work,
	input  wire logic [2:0]                   exec_bit,
	input  wire logic                         exec_dest_status,
	output logic      [csf_pkg::DATA_W-1:0]   alu_result,
	output logic                              alu_result_valid,
	// reset sequencer and watchdog
	input  wire logic                         device_reset,
	input  wire csf_pkg::csf_cause_type       device_reset_cause,
	input  wire logic                         watchdog_expired,
	// status outputs
	output logic      [csf_pkg::DATA_W-1:0]   status_value,
	output logic                              page_preselect,
	output logic      [csf_pkg::PC_W-1:0]     page_base
);
	import csf_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [2:0]        upper_q;
	logic [2:0]        upper_d;
	logic              timeout_q;
	logic              powerdown_q;
	logic [2:0]        flags_q;
	logic [2:0]        flags_d;
	logic [7:0]        rdata_q;
	logic [7:0]        result_q;
	logic              result_valid_q;
	logic              page_q;
	logic [9:0]        page_base_q;
	logic [7:0]        status_word;

	// ----------------------------------------------------------------
	// alu
	// ----------------------------------------------------------------
	logic [8:0]        sum9;
	logic [8:0]        diff9;
	logic [4:0]        nib_sum;
	logic [4:0]        nib_diff;
	logic [7:0]        result;
	logic              new_zero;
	logic              new_nibble;
	logic              new_carry;
	logic              aff_zero;
	logic              aff_nibble;
	logic              aff_carry;
	logic              aff_any;
	logic              writes_file;
	logic              exec_to_status;
	logic              bus_to_status;
	logic [7:0]        bit_mask;
	logic              addr_hit;
	logic              power_up_reset;
	logic              dog_clear_op;
	logic              halt_op;

	assign sum9     = {1'b0, exec_file} + {1'b0, exec_work};
	assign diff9    = {1'b0, exec_file} - {1'b0, exec_work};
	assign nib_sum  = {1'b0, exec_file[3:0]} + {1'b0, exec_work[3:0]};
	assign nib_diff = {1'b0, exec_file[3:0]} - {1'b0, exec_work[3:0]};
	assign bit_mask = 8'h01 << exec_bit;

	always_comb begin
		result      = exec_file;
		new_carry   = flags_q[BIT_CARRY];
		new_nibble  = flags_q[BIT_NIBBLE];
		aff_zero    = 1'b0;
		aff_nibble  = 1'b0;
		aff_carry   = 1'b0;
		writes_file = 1'b1;
		case (exec_op)
			OP_ADD: begin
				result     = sum9[7:0];
				new_carry  = sum9[8];
				new_nibble = nib_sum[4];
				aff_zero   = 1'b1;
				aff_nibble = 1'b1;
				aff_carry  = 1'b1;
			end
			OP_SUB: begin
				result     = diff9[7:0];
				new_carry  = ~diff9[8];
				new_nibble = ~nib_diff[4];
				aff_zero   = 1'b1;
				aff_nibble = 1'b1;
				aff_carry  = 1'b1;
			end
			OP_AND: begin
				result   = exec_file & exec_work;
				aff_zero = 1'b1;
			end
			OP_OR: begin
				result   = exec_file | exec_work;
				aff_zero = 1'b1;
			end
			OP_XOR: begin
				result   = exec_file ^ exec_work;
				aff_zero = 1'b1;
			end
			OP_ROT_R: begin
				result    = {flags_q[BIT_CARRY], exec_file[7:1]};
				new_carry = exec_file[0];
				aff_carry = 1'b1;
			end
			OP_ROT_L: begin
				result    = {exec_file[6:0], flags_q[BIT_CARRY]};
				new_carry = exec_file[7];
				aff_carry = 1'b1;
			end
			OP_CLR_FILE: begin
				result   = 8'h00;
				aff_zero = 1'b1;
			end
			// these three leave the alu flags alone unless their result goes to the status register
			OP_BIT_CLR: begin
				result = exec_file & ~bit_mask;
			end
			OP_BIT_SET: begin
				result = exec_file | bit_mask;
			end
			OP_MOV_FILE: begin
				result = exec_work;
			end
			default: begin
				writes_file = 1'b0;
			end
		endcase
	end

	assign new_zero       = (result == 8'h00);
	assign aff_any        = aff_zero | aff_nibble | aff_carry;
	assign exec_to_status = exec_valid & writes_file & exec_dest_status;
	// one address decode serves both strobes
	assign addr_hit       = (reg_addr == STATUS_OFFSET);
	assign bus_to_status  = reg_write & addr_hit;

	// ----------------------------------------------------------------
	// upper bits: wake causes and page select
	// ----------------------------------------------------------------
	// write priority, lowest first: bus write, instruction result, device
	// reset. software may set the wake bits as well; only a later device
	// reset puts them back to the true cause, so firmware should not rely
	// on writing them
	always_comb begin
		upper_d = upper_q;
		if (bus_to_status) begin
			upper_d = reg_wdata[BIT_PIN_WAKE:BIT_PAGE];
		end
		if (exec_to_status) begin
			upper_d = result[BIT_PIN_WAKE:BIT_PAGE];
		end
		// a device reset restarts the core, so it overrides any write
		if (device_reset) begin
			upper_d = RST_UPPER;
			if (device_reset_cause == CAUSE_PIN_WAKE) begin
				upper_d[BIT_PIN_WAKE - BIT_PAGE] = 1'b1;
			end
			if (device_reset_cause == CAUSE_COMP_WAKE) begin
				upper_d[BIT_COMP_WAKE - BIT_PAGE] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			upper_q <= RST_UPPER;
		end else begin
			upper_q <= upper_d;
		end
	end

	// ----------------------------------------------------------------
	// event decode
	// ----------------------------------------------------------------
	assign power_up_reset = device_reset & (device_reset_cause == CAUSE_POWER_UP);
	assign dog_clear_op   = exec_valid & (exec_op == OP_WATCHDOG_CLR);
	assign halt_op        = exec_valid & (exec_op == OP_HALT);

	// ----------------------------------------------------------------
	// timeout and powerdown: never written by the bus or an instruction result
	// ----------------------------------------------------------------
	// expiry is the hardware event, so it beats every set of the flag
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			timeout_q <= RST_TIMEOUT;
		end else if (watchdog_expired) begin
			timeout_q <= 1'b0;
		end else if (power_up_reset) begin
			timeout_q <= RST_TIMEOUT;
		end else if (dog_clear_op || halt_op) begin
			timeout_q <= 1'b1;
		end
	end

	// only halt enters power-down; power-up and a watchdog clear leave it
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			powerdown_q <= RST_POWERDOWN;
		end else if (power_up_reset) begin
			powerdown_q <= RST_POWERDOWN;
		end else if (dog_clear_op) begin
			powerdown_q <= 1'b1;
		end else if (halt_op) begin
			powerdown_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// alu flags
	// ----------------------------------------------------------------
	always_comb begin
		flags_d = flags_q;
		if (bus_to_status) begin
			flags_d = reg_wdata[BIT_ZERO:BIT_CARRY];
		end
		if (exec_valid && writes_file) begin
			// a direct write lands only when the op leaves the flags alone
			if (exec_dest_status && !aff_any) begin
				flags_d = result[BIT_ZERO:BIT_CARRY];
			end
			if (aff_zero) begin
				flags_d[BIT_ZERO] = new_zero;
			end
			if (aff_nibble) begin
				flags_d[BIT_NIBBLE] = new_nibble;
			end
			if (aff_carry) begin
				flags_d[BIT_CARRY] = new_carry;
			end
		end
	end

	// left undefined by the device; zero is chosen so simulation stays clean
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flags_q <= RST_ALU_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------------------------------
	// alu result to the register file
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			result_q       <= RST_RESULT;
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= exec_valid & writes_file & ~exec_dest_status;
			if (exec_valid && writes_file) begin
				result_q <= result;
			end
		end
	end

	// ----------------------------------------------------------------
	// page select
	// ----------------------------------------------------------------
	// the pc logic sees the page on the same edge as the write lands
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			page_q      <= 1'b0;
			page_base_q <= PAGE0_BASE;
		end else begin
			page_q <= upper_d[0];
			if (upper_d[0]) begin
				page_base_q <= PAGE1_BASE;
			end else begin
				page_base_q <= PAGE0_BASE;
			end
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_q <= READ_UNMAPPED;
		end else if (reg_read && addr_hit) begin
			rdata_q <= status_word;
		end else begin
			rdata_q <= READ_UNMAPPED;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata        = rdata_q;
	assign alu_result       = result_q;
	assign alu_result_valid = result_valid_q;
	assign status_word      = {upper_q, timeout_q, powerdown_q, flags_q};
	assign status_value     = status_word;
	assign page_preselect   = page_q;
	assign page_base        = page_base_q;

	// page size is fixed by the base constants; kept for the pc side
	localparam int UNUSED_PAGE_SIZE = PAGE_SIZE;

endmodule // csf_status_reg

// ### tb/csf_core_model.sv
// csf_core_model: behavioural execute stage driving the op port of the status register.
// assumes one caller of issue() at a time, on the register's clock.
`timescale 1ns/10ps
module csf_core_model (
	input	wire logic				clock,
	output	logic					exec_valid,
	output	csf_pkg::csf_op_type	exec_op,
	output	logic [7:0]				exec_file,
	output	logic [7:0]				exec_work,
	output	logic [2:0]				exec_bit,
	output	logic					exec_dest_status
);
	import csf_pkg::*;
	// ----
	// op issue
	// ----
	initial begin
		exec_valid = 1'b0;
		exec_op = OP_NONE;
		{exec_file, exec_work, exec_bit, exec_dest_status} = 20'h0_0000;
	end
	// released file and work operands are inverted so a stale value never passes for good data
	task automatic issue(csf_op_type op, logic [7:0] f, w, logic [2:0] b, logic d);
		@(posedge clock);
		exec_valid <= 1'b1;
		exec_op <= op;
		exec_file <= f;
		exec_work <= w;
		exec_bit <= b;
		exec_dest_status <= d;
		@(posedge clock);
		exec_valid <= 1'b0;
		exec_file <= ~f;
		exec_work <= ~w;
	endtask
endmodule // csf_core_model

// ### tb/csf_status_reg_assertions.sv
// csf_status_reg_assertions: port-level checks of the core status flag register.
// assumes it is bound into csf_status_reg; rst_n synchronous, active low.
`timescale 1ns/10ps
module csf_status_reg_assertions #(
	parameter int PAGE_SIZE = csf_pkg::PAGE_WORDS
) (
	input	wire logic					clock,
	input	wire logic					rst_n,
	input	wire logic [4:0]			reg_addr,
	input	wire logic					reg_write,
	input	wire logic					exec_valid,
	input	wire csf_pkg::csf_op_type	exec_op,
	input	wire logic [7:0]			exec_file,
	input	wire logic [7:0]			exec_work,
	input	wire logic					exec_dest_status,
	input	wire logic [7:0]			alu_result,
	input	wire logic					alu_result_valid,
	input	wire logic					device_reset,
	input	wire csf_pkg::csf_cause_type	device_reset_cause,
	input	wire logic					watchdog_expired,
	input	wire logic [7:0]			status_value,
	input	wire logic					page_preselect,
	input	wire logic [9:0]			page_base
);
	import csf_pkg::*;
	// ----
	// checks
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_op(csf_op_type o, logic d);
		exec_valid && exec_op == o && exec_dest_status == d && !reg_write
			&& !device_reset && !watchdog_expired;
	endsequence
	sequence s_cause(csf_cause_type c);
		device_reset && device_reset_cause == c;
	endsequence
	a_page_copy: assert property (page_preselect == status_value[BIT_PAGE])
		else $error("page copy differs from the register");
	a_page_base: assert property (page_base == (page_preselect ? PAGE1_BASE : PAGE0_BASE))
		else $error("page base wrong");
	a_ro_bits: assert property (reg_write && reg_addr == STATUS_OFFSET && !exec_valid
		&& !device_reset && !watchdog_expired |=> $stable(status_value[4:3]))
		else $error("bus write changed bits 4..3");
	a_clr_file: assert property (s_op(OP_CLR_FILE, 1'b1) |=> status_value[7:5] == 3'h0
		&& status_value[2] && $stable(status_value[4:3]) && $stable(status_value[1:0]))
		else $error("clear of register wrong");
	a_bit_keep: assert property ((s_op(OP_BIT_CLR, 1'b0) or s_op(OP_BIT_SET, 1'b0)
		or s_op(OP_MOV_FILE, 1'b0)) |=> $stable(status_value[2:0]))
		else $error("bit op touched alu flags");
	a_pin_wake: assert property (s_cause(CAUSE_PIN_WAKE) |=> status_value[7:5] == 3'h4)
		else $error("pin wake flags wrong");
	a_comp_wake: assert property (s_cause(CAUSE_COMP_WAKE) |=> status_value[7:5] == 3'h2)
		else $error("comparator wake flags wrong");
	a_power_up: assert property (s_cause(CAUSE_POWER_UP) |=> status_value[7:3] == 5'h03)
		else $error("power-up flags wrong");
	a_wdt_expire: assert property (watchdog_expired && !device_reset |=> !status_value[4])
		else $error("expiry left timeout set");
	a_halt_flags: assert property (s_op(OP_HALT, exec_dest_status) |=> status_value[4:3] == 2'h2)
		else $error("halt flags wrong");
	a_add_flags: assert property (s_op(OP_ADD, 1'b0) |=> alu_result_valid
		&& status_value[2] == (alu_result == 8'h00)
		&& status_value[0] == ($past(exec_file) + $past(exec_work) > 9'h0FF))
		else $error("add flags wrong");
endmodule // csf_status_reg_assertions

// ### tb/csf_status_reg_bench.sv
// csf_status_reg_bench: self-checking bench of the core status flag register.
// assumes csf_core_model drives the op port and the bench plays bus and sequencer.
`timescale 1ns/10ps
module csf_status_reg_bench;
	import csf_pkg::*;
	localparam int	PAGE_SIZE = PAGE_WORDS;
	logic			clock = 1'b0;
	logic			rst_n = 1'b0;
	logic			reg_write = 1'b0;
	logic			reg_read = 1'b0;
	logic			rd_p = 1'b0;
	logic			device_reset = 1'b0;
	logic			watchdog_expired = 1'b0;
	logic [4:0]		reg_addr = 5'h00;
	logic [7:0]		reg_wdata = 8'h00;
	logic [7:0]		reg_rdata, alu_result, status_value, st, exec_file, exec_work;
	logic			alu_result_valid, page_preselect, exec_valid, exec_dest_status;
	logic [2:0]		exec_bit;
	logic [9:0]		page_base;
	csf_op_type		exec_op;
	csf_cause_type	device_reset_cause = CAUSE_OTHER;
	logic [15:0]	e, qa[$], qr[$];
	int				n_mismatch = 0;
	int				num_checks = 0;
	int				cyc = 0;
	always #4 clock = ~clock;
	csf_status_reg #(.PAGE_SIZE(PAGE_SIZE)) dut_u (
		.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.exec_valid(exec_valid), .exec_op(exec_op), .exec_file(exec_file),
		.exec_work(exec_work), .exec_bit(exec_bit), .exec_dest_status(exec_dest_status),
		.alu_result(alu_result), .alu_result_valid(alu_result_valid),
		.device_reset(device_reset), .device_reset_cause(device_reset_cause),
		.watchdog_expired(watchdog_expired),
		.status_value(status_value), .page_preselect(page_preselect),
		.page_base(page_base)
	);
	csf_core_model core_u (
		.clock(clock), .exec_valid(exec_valid), .exec_op(exec_op),
		.exec_file(exec_file), .exec_work(exec_work), .exec_bit(exec_bit),
		.exec_dest_status(exec_dest_status)
	);
	// ----
	// tasks
	// ----
	function automatic logic [7:0] lf(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmp(logic [15:0] got, exp, m);
		num_checks++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// status at once, page copy one cycle later
	task automatic chk;
		#1 cmp(status_value, st, 16'h00FF);
		@(posedge clock);
		#1 cmp({page_preselect, page_base}, {st[5], st[5] ? PAGE1_BASE : PAGE0_BASE}, 16'h07FF);
	endtask
	task automatic wr(logic [4:0] a, logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		if (a == STATUS_OFFSET) st = {d[7:5], st[4:3], d[2:0]};
		chk();
	endtask
	task automatic rd(logic [4:0] a);
		qr.push_back(a == STATUS_OFFSET ? st : READ_UNMAPPED);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
	endtask
	task automatic dres(csf_cause_type c);
		@(posedge clock);
		device_reset <= 1'b1;
		device_reset_cause <= c;
		@(posedge clock);
		device_reset <= 1'b0;
		st[7:5] = {c == CAUSE_PIN_WAKE, c == CAUSE_COMP_WAKE, 1'b0};
		if (c == CAUSE_POWER_UP) st[4:3] = 2'b11;
		chk();
	endtask
	task automatic exe(csf_op_type op, logic [7:0] f, w, logic [2:0] b, logic d);
		logic [8:0] s;
		logic [2:0] m, fl;
		logic [7:0] km;
		logic nc;
		{s, nc, m, km} = {9'h000, 1'b0, 3'h4, 8'hFF};
		case (op)
			OP_ADD: {s, nc, m} = {{1'b0, f} + {1'b0, w}, f[3:0] + w[3:0] > 15, 3'h7};
			OP_SUB: {s, nc, m} = {f >= w, f - w, f[3:0] >= w[3:0], 3'h7};
			OP_AND: s = f & w;
			OP_OR: s = f | w;
			OP_XOR: s = f ^ w;
			OP_ROT_R: {s, km, m} = {f[0], 1'b0, f[7:1], 8'h7F, 3'h1};
			OP_ROT_L: {s, km, m} = {f[7], f[6:0], 1'b0, 8'hFE, 3'h1};
			OP_BIT_CLR: {s, m} = {1'b0, f & ~(8'h01 << b), 3'h0};
			OP_BIT_SET: {s, m} = {1'b0, f | (8'h01 << b), 3'h0};
			OP_MOV_FILE: {s, m} = {1'b0, w, 3'h0};
			OP_CLR_FILE: s = 9'h000;
			default: m = 3'h0;
		endcase
		fl = {s[7:0] == 8'h00, nc, s[8]};
		core_u.issue(op, f, w, b, d);
		if (op == OP_WATCHDOG_CLR) st[4:3] = 2'b11;
		else if (op == OP_HALT) st[4:3] = 2'b10;
		else if (d) st = {s[7:5], st[4:3], m == 0 ? s[2:0] : (m & fl) | (~m & st[2:0])};
		else begin
			st[2:0] = (m & fl) | (~m & st[2:0]);
			qa.push_back({km, s[7:0]});
		end
		chk();
	endtask
	// ----
	// result watcher and timeout
	// ----
	always @(posedge clock) begin
		cyc <= cyc + 1;
		rd_p <= reg_read;
		if (rd_p) cmp(reg_rdata, qr.pop_front(), 16'h00FF);
		// before the first reset edge the valid flop is still unknown
		if (rst_n && alu_result_valid !== 1'b0) begin
			if (qa.size() == 0) cmp(16'h0001, 16'h0000, 16'h0001);
			else begin
				e = qa.pop_front();
				cmp(alu_result, e[7:0], e[15:8]);
			end
		end
		if (cyc == 5000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		logic [7:0] x;
		x = 8'h37;
		st = {RST_UPPER, RST_TIMEOUT, RST_POWERDOWN, RST_ALU_FLAGS};
		repeat (11) @(posedge clock);
		#1 cmp({status_value, page_base[9:2]}, {st, 8'h00}, 16'hFFFF);
		@(posedge clock);
		rst_n <= 1'b1;
		rd(STATUS_OFFSET);
		rd(5'h1F);
		exe(OP_ADD, 8'hF8, 8'h08, 3'h0, 1'b0);
		exe(OP_SUB, 8'h10, 8'h01, 3'h0, 1'b0);
		exe(OP_SUB, 8'h05, 8'h05, 3'h0, 1'b0);
		for (int i = 0; i < 66; i++) begin
			exe(csf_op_type'(1 + i % 11), x, lf(x), x[2:0], 1'b0);
			x = lf(lf(x));
		end
		wr(STATUS_OFFSET, 8'hFF);
		wr(5'h1F, 8'h00);
		rd(STATUS_OFFSET);
		exe(OP_CLR_FILE, 8'h5A, 8'h00, 3'h0, 1'b1);
		exe(OP_ADD, 8'h80, 8'h80, 3'h0, 1'b1);
		// page bit is only ever used to pick the program page
		exe(OP_BIT_SET, st, 8'h00, 3'h5, 1'b1);
		exe(OP_MOV_FILE, st, 8'hA6, 3'h0, 1'b1);
		exe(OP_HALT, 8'h00, 8'h00, 3'h0, 1'b0);
		@(posedge clock);
		watchdog_expired <= 1'b1;
		@(posedge clock);
		watchdog_expired <= 1'b0;
		st[4] = 1'b0;
		chk();
		exe(OP_WATCHDOG_CLR, 8'h00, 8'h00, 3'h0, 1'b0);
		exe(OP_HALT, 8'h00, 8'h00, 3'h0, 1'b0);
		for (int c = 1; c < 5; c++) dres(csf_cause_type'(c % 4));
		rd(STATUS_OFFSET);
		repeat (2) @(posedge clock);
		cmp(qa.size(), 16'h0000, 16'hFFFF);
		wrap_up();
	end
endmodule // csf_status_reg_bench
bind csf_status_reg csf_status_reg_assertions #(.PAGE_SIZE(PAGE_SIZE)) chk_u (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
	.exec_valid(exec_valid), .exec_op(exec_op), .exec_file(exec_file),
	.exec_work(exec_work), .exec_dest_status(exec_dest_status),
	.alu_result(alu_result), .alu_result_valid(alu_result_valid),
	.device_reset(device_reset), .device_reset_cause(device_reset_cause),
	.watchdog_expired(watchdog_expired), .status_value(status_value),
	.page_preselect(page_preselect), .page_base(page_base)
);
